// File: rtl/ext_irq_detect.sv
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Edge select only matters when the pin's sense bit picks edge mode.
// - Edge code 00 is falling, 01 rising, 10 both; 11 detects nothing.
// - Edge select holds pins 0..3 at bits 15:14..9:8, reset to zero.
// - Reserved bits of both registers read zero; writes to them are lost.
// - Flags sit at bits 7..4 for pins 0..3, reset to zero, set on detect.
// - A flag clears on a write of 0 only after it was read as 1.
// - Level mode clears the flag when exception runs with the pin high.
// - Edge mode clears the flag when that pin's exception runs.
// - A software clear in edge mode withdraws the pending request.
// - Sense bit 0 detects a low level, 1 detects the selected edge.
module ext_irq_detect
  import irq_edge_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Register port
  input  wire reg_req_t            req_i,
  output logic        [DATA_W-1:0] rdata_o,
  // External request pins, low active
  input  wire logic [NUM_PINS-1:0] ext_request_pins_n_i,
  // Acknowledges from exception and transfer logic
  input  wire ack_t                ack_i,
  // Requests to priority logic and interrupt
  output logic      [NUM_PINS-1:0] pending_o,
  output logic                     irq_o
);

  logic [NUM_PINS-1:0] pin_lvl;
  logic [NUM_PINS-1:0] det;
  logic [DATA_W-1:0]   sense_q;
  logic [DATA_W-1:0]   edge_q;
  logic [NUM_PINS-1:0] flag_q;
  logic [NUM_PINS-1:0] flag_d;
  logic [NUM_PINS-1:0] seen_one_q;
  logic [NUM_PINS-1:0] evt_q;
  logic [NUM_PINS-1:0] evt_mask_q;
  logic [NUM_PINS-1:0] sw_clr;
  logic [NUM_PINS-1:0] hw_clr;
  logic [DATA_W-1:0]   rdata_d;
  logic                wr_flags;

  function automatic logic [DATA_W-1:0] flags_to_word(
    input logic [NUM_PINS-1:0] f
  );
    logic [DATA_W-1:0] w;
    w = '0;
    for (int n = 0; n < NUM_PINS; n++) begin
      w[FLAG_MSB-n] = f[n];
    end
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Synchronise and detect

  pin_sync #(
    .WIDTH (NUM_PINS)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (ext_request_pins_n_i),
    .sync_o  (pin_lvl)
  );

  for (genvar n = 0; n < NUM_PINS; n++) begin : g_det
    pin_detect u_det (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .sense_edge_i (sense_q[SENSE_MSB-n]),
      .edge_sel_i   (edge_q[EDGE_HI_MSB-2*n -: 2]),
      .level_i      (pin_lvl[n]),
      .event_o      (det[n])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sense_q <= SENSE_RST;
      edge_q  <= EDGE_SEL_RST;
    end else if (req_i.wr) begin
      if (req_i.addr == OFS_SENSE) begin
        sense_q <= req_i.wdata & SENSE_WMASK;
      end else if (req_i.addr == OFS_EDGE_SEL) begin
        edge_q  <= req_i.wdata & EDGE_WMASK;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request flags

  assign wr_flags = req_i.wr && req_i.addr == OFS_FLAGS;

  always_comb begin
    for (int n = 0; n < NUM_PINS; n++) begin
      sw_clr[n] = wr_flags && seen_one_q[n]
                  && !req_i.wdata[FLAG_MSB-n];
      hw_clr[n] = (ack_i.exc_taken[n]
                   && (sense_q[SENSE_MSB-n] || pin_lvl[n]))
                  || (ack_i.xfer_start[n]
                      && !ack_i.xfer_irq_disable_sel);
      // A new detection wins over any clear in the same cycle
      flag_d[n] = det[n] ? 1'b1 : (flag_q[n] && !sw_clr[n] && !hw_clr[n]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= FLAGS_RST[NUM_PINS-1:0];
    end else begin
      flag_q <= flag_d;
    end
  end

  // A read arms the clear only for bits that were one; a write disarms
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_one_q <= '0;
    end else if (req_i.rd && req_i.addr == OFS_FLAGS) begin
      seen_one_q <= flag_q;
    end else if (wr_flags) begin
      seen_one_q <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event status, mask and interrupt

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_q <= '0;
    end else if (req_i.wr && req_i.addr == OFS_IRQ_STATUS) begin
      evt_q <= (evt_q & ~req_i.wdata[NUM_PINS-1:0]) | (flag_d & ~flag_q);
    end else begin
      evt_q <= evt_q | (flag_d & ~flag_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_mask_q <= '0;
    end else if (req_i.wr && req_i.addr == OFS_IRQ_MASK) begin
      evt_mask_q <= req_i.wdata[NUM_PINS-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o     <= 1'b0;
      pending_o <= '0;
    end else begin
      irq_o     <= |(evt_q & evt_mask_q);
      pending_o <= flag_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port

  always_comb begin
    rdata_d = '0;
    if (req_i.addr == OFS_SENSE) begin
      rdata_d = sense_q;
    end else if (req_i.addr == OFS_EDGE_SEL) begin
      rdata_d = edge_q;
    end else if (req_i.addr == OFS_FLAGS) begin
      rdata_d = flags_to_word(flag_q);
    end else if (req_i.addr == OFS_IRQ_STATUS) begin
      rdata_d = {{(DATA_W-NUM_PINS){1'b0}}, evt_q};
    end else if (req_i.addr == OFS_IRQ_MASK) begin
      rdata_d = {{(DATA_W-NUM_PINS){1'b0}}, evt_mask_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (req_i.rd) begin
      rdata_o <= rdata_d;
    end else begin
      rdata_o <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  flag_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    det[0] |=> flag_q[0])
    else $error("flag 0 not set after detection");

  sw_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_flags && !seen_one_q[1] && !hw_clr[1] && !det[1] && flag_q[1])
    |=> flag_q[1])
    else $error("flag 1 cleared without a prior read of one");

  // Masters may leave an idle cycle between the read and the write
  read_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req_i.rd && req_i.addr == OFS_FLAGS && flag_q[2])
    ##1 (!req_i.wr && !req_i.rd)
    ##1 (wr_flags && !req_i.wdata[FLAG_MSB-2] && !det[2])
    |=> !flag_q[2] && !pending_o[2])
    else $error("read-one then write-zero did not clear flag 2");

  edge_exc_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ack_i.exc_taken[0] && sense_q[SENSE_MSB] && !det[0])
    |=> !flag_q[0])
    else $error("edge exception did not clear flag 0");

  level_exc_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ack_i.exc_taken[0] && !sense_q[SENSE_MSB] && !pin_lvl[0])
    |=> flag_q[0])
    else $error("level flag cleared while pin low");

  xfer_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ack_i.xfer_start[1] && !ack_i.xfer_irq_disable_sel && !det[1])
    |=> !flag_q[1])
    else $error("transfer start did not clear flag 1");

  xfer_keep_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ack_i.xfer_start[1] && ack_i.xfer_irq_disable_sel && flag_q[1]
     && !req_i.wr && !ack_i.exc_taken[1])
    |=> flag_q[1])
    else $error("transfer start cleared flag 1 with disable set");

  edge_rsvd_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sense_q[SENSE_MSB-2] && edge_q[EDGE_HI_MSB-4 -: 2] == 2'b11)
    |-> !det[2])
    else $error("reserved edge code produced a detection");

  edge_fall_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sense_q[SENSE_MSB] && edge_q[EDGE_HI_MSB -: 2] == EDGE_FALL
     && $fell(pin_lvl[0])) |-> det[0])
    else $error("falling edge on pin 0 not detected");

  edge_rise_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sense_q[SENSE_MSB-1] && edge_q[EDGE_HI_MSB-2 -: 2] == EDGE_RISE
     && $rose(pin_lvl[1])) |-> det[1])
    else $error("rising edge on pin 1 not detected");

  edge_both_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sense_q[SENSE_MSB-3] && edge_q[EDGE_HI_MSB-6 -: 2] == EDGE_BOTH
     && $changed(pin_lvl[3])) |-> det[3])
    else $error("edge on pin 3 not detected in both-edge mode");

  edge_quiet_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sense_q[SENSE_MSB-2] && $stable(pin_lvl[2])) |-> !det[2])
    else $error("edge mode detected a steady pin 2");

  level_mode_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !sense_q[SENSE_MSB-1] |-> det[1] == !pin_lvl[1])
    else $error("level mode detection does not follow pin");

  level_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!sense_q[SENSE_MSB-2] && !pin_lvl[2]) |=> flag_q[2])
    else $error("low level on pin 2 did not set its flag");

  // Sticky flags: only a flag write or an acknowledge may drop them
  flag_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (flag_q[3] && !req_i.wr && !ack_i.exc_taken[3] && !ack_i.xfer_start[3])
    |=> flag_q[3])
    else $error("flag 3 dropped without a clear");

  no_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!flag_q[3] && !det[3]) |=> !flag_q[3])
    else $error("flag 3 set without a detection");

  sw_noclr_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_flags && req_i.wdata[FLAG_MSB-3] && flag_q[3]
     && !ack_i.exc_taken[3] && !ack_i.xfer_start[3])
    |=> flag_q[3])
    else $error("writing one cleared flag 3");

  rdata_idle_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !req_i.rd |=> rdata_o == '0)
    else $error("read data not zero outside a read");

  edge_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ($past(req_i.rd) && $past(req_i.addr) == OFS_EDGE_SEL)
    |-> (rdata_o & ~EDGE_WMASK) == '0)
    else $error("reserved edge select bits read non-zero");

  flag_rsvd_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ($past(req_i.rd) && $past(req_i.addr) == OFS_FLAGS)
    |-> (rdata_o & ~FLAG_WMASK) == '0)
    else $error("reserved flag bits read non-zero");

  rsvd_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ($past(req_i.rd) && !$past(rst_i) && $past(req_i.addr) == OFS_FLAGS)
    |-> rdata_o[DATA_W-1:8] == '0)
    else $error("upper flag bits read non-zero");

endmodule

// File: rtl/irq_edge_pkg.sv
package irq_edge_pkg;

  localparam int          NUM_PINS       = 4;
  localparam int          ADDR_W         = 4;
  localparam int          DATA_W         = 16;

  // Register offsets
  localparam logic [3:0]  OFS_SENSE      = 4'h0;
  localparam logic [3:0]  OFS_EDGE_SEL   = 4'h2;
  localparam logic [3:0]  OFS_FLAGS      = 4'h4;
  localparam logic [3:0]  OFS_IRQ_STATUS = 4'h6;
  localparam logic [3:0]  OFS_IRQ_MASK   = 4'h8;

  // Field positions: pin n at bit (MSB - n) or pair (HI - 2n)
  localparam int          SENSE_MSB      = 7;
  localparam int          EDGE_HI_MSB    = 15;
  localparam int          FLAG_MSB       = 7;

  // Reset values
  localparam logic [15:0] EDGE_SEL_RST   = 16'h0000;
  localparam logic [15:0] SENSE_RST      = 16'h0000;
  localparam logic [15:0] FLAGS_RST      = 16'h0000;

  // Writable masks; other bits are reserved and read zero
  localparam logic [15:0] SENSE_WMASK    = 16'h00f0;
  localparam logic [15:0] EDGE_WMASK     = 16'hff00;
  localparam logic [15:0] FLAG_WMASK     = 16'h00f0;
  localparam logic [15:0] EVT_WMASK      = 16'h000f;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_RSVD = 2'b11
  } edge_sel_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] exc_taken;
    logic [NUM_PINS-1:0] xfer_start;
    logic                xfer_irq_disable_sel;
  } ack_t;

endpackage

// File: rtl/pin_detect.sv
`timescale 1ns/1ps
module pin_detect
  import irq_edge_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Configuration and level
  input  wire logic       sense_edge_i,
  input  wire logic [1:0] edge_sel_i,
  input  wire logic       level_i,
  // Detection
  output logic            event_o
);

  logic prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= level_i;
    end
  end

  always_comb begin
    event_o = 1'b0;
    if (!sense_edge_i) begin
      event_o = !level_i;
    end else begin
      case (edge_sel_t'(edge_sel_i))
        EDGE_FALL: event_o = prev_q && !level_i;
        EDGE_RISE: event_o = !prev_q && level_i;
        EDGE_BOTH: event_o = prev_q != level_i;
        default:   event_o = 1'b0;
      endcase
    end
  end

endmodule

// File: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
  import irq_edge_pkg::*;
#(
  parameter int WIDTH = NUM_PINS
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Pins and synchronised levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync: WIDTH must be positive");
  end

  // Idle high resets keep a low-active pin from looking asserted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '1;
      sync_o <= '1;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// File: verif/pin_drv.sv
`timescale 1ns/1ps
module pin_drv
  import irq_edge_pkg::*;
(
  // Clock and wanted levels
  input  wire logic                clk_i,
  input  wire logic [NUM_PINS-1:0] lvl_i,
  // Request pins, low active
  output logic      [NUM_PINS-1:0] pins_n_o
);
  // Pins move off the core edge, as a truly async source would
  initial pins_n_o = '1;
  always @(posedge clk_i) begin
    pins_n_o <= #3 lvl_i;
  end
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb
  import irq_edge_pkg::*;
();
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  reg_req_t    req = '0;
  ack_t        ack = '0;
  logic [3:0]  lvl = 4'hf;
  logic [3:0]  pins_n;
  logic [15:0] rdata;
  logic [3:0]  pend;
  logic        irq;
  int          err_count = 0;
  int          total_checks = 0;

  always #5 clk = ~clk;

  pin_drv pin_drv_i (.clk_i(clk), .lvl_i(lvl), .pins_n_o(pins_n));
  ext_irq_detect ext_irq_detect_i (
    .clk_i(clk), .rst_i(rst), .req_i(req), .rdata_o(rdata),
    .ext_request_pins_n_i(pins_n), .ack_i(ack),
    .pending_o(pend), .irq_o(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask

  // Data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    #1;
    chk(rdata, exp);
  endtask

  task ack_p(input logic [3:0] ex, xs, input logic dis);
    @(posedge clk);
    ack <= '{exc_taken: ex, xfer_start: xs, xfer_irq_disable_sel: dis};
    @(posedge clk);
    ack <= '0;
    cyc(1);
  endtask

  task clr(input logic [15:0] f);
    rd(OFS_FLAGS, f);
    wr(OFS_FLAGS, 16'h0000);
    rd(OFS_FLAGS, 16'h0000);
    chk({12'h000, pend}, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(OFS_SENSE, 16'h0000);
    rd(OFS_EDGE_SEL, 16'h0000);
    rd(OFS_FLAGS, 16'h0000);
    rd(OFS_IRQ_STATUS, 16'h0000);
    rd(OFS_IRQ_MASK, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    $display("test reset done");
  endtask

  task t_regs;
    wr(OFS_EDGE_SEL, 16'hffff);
    rd(OFS_EDGE_SEL, 16'hff00);
    wr(4'he, 16'hffff);
    rd(4'he, 16'h0000);
    wr(OFS_SENSE, 16'hffff);
    rd(OFS_SENSE, 16'h00f0);
    rd(OFS_FLAGS, 16'h0000);
    $display("test regs done");
  endtask

  task t_edges;
    logic [1:0]  c;
    logic [15:0] f;
    logic [15:0] r;
    wr(OFS_SENSE, 16'h00f0);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      f = (c == EDGE_FALL || c == EDGE_BOTH) ? 16'h00f0 : 16'h0000;
      r = (c == EDGE_RISE || c == EDGE_BOTH) ? 16'h00f0 : 16'h0000;
      wr(OFS_EDGE_SEL, {c, c, c, c, 8'h00});
      lvl <= 4'h0;
      cyc(6);
      clr(f);
      lvl <= 4'hf;
      cyc(6);
      clr(r);
    end
    $display("test edges done");
  endtask

  task t_level;
    wr(OFS_SENSE, 16'h0000);
    wr(OFS_EDGE_SEL, 16'h5500);
    lvl <= 4'h0;
    cyc(6);
    rd(OFS_FLAGS, 16'h00f0);
    ack_p(4'hf, 4'h0, 1'b1);
    rd(OFS_FLAGS, 16'h00f0);
    // A write while the pin is low disarms without clearing
    wr(OFS_FLAGS, 16'h0000);
    lvl <= 4'hf;
    cyc(6);
    wr(OFS_FLAGS, 16'h0000);
    rd(OFS_FLAGS, 16'h00f0);
    ack_p(4'hf, 4'h0, 1'b1);
    rd(OFS_FLAGS, 16'h0000);
    $display("test level done");
  endtask

  task t_ack;
    wr(OFS_SENSE, 16'h00f0);
    wr(OFS_EDGE_SEL, 16'h0000);
    wr(OFS_IRQ_STATUS, 16'h000f);
    wr(OFS_IRQ_MASK, 16'h0000);
    lvl <= 4'h0;
    cyc(6);
    #1;
    chk({12'h000, pend}, 16'h000f);
    chk({15'h0000, irq}, 16'h0000);
    // Writing ones keeps every flag and disarms the clear
    rd(OFS_FLAGS, 16'h00f0);
    wr(OFS_FLAGS, 16'h00f0);
    rd(OFS_FLAGS, 16'h00f0);
    ack_p(4'h1, 4'h0, 1'b0);
    rd(OFS_FLAGS, 16'h0070);
    ack_p(4'h0, 4'h2, 1'b1);
    rd(OFS_FLAGS, 16'h0070);
    ack_p(4'h0, 4'h2, 1'b0);
    rd(OFS_FLAGS, 16'h0030);
    chk({12'h000, pend}, 16'h000c);
    rd(OFS_IRQ_STATUS, 16'h000f);
    wr(OFS_IRQ_MASK, 16'h000f);
    cyc(2);
    #1;
    chk({15'h0000, irq}, 16'h0001);
    wr(OFS_IRQ_STATUS, 16'h000f);
    cyc(2);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    rd(OFS_IRQ_STATUS, 16'h0000);
    lvl <= 4'hf;
    cyc(6);
    clr(16'h0030);
    $display("test ack done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    cyc(6);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_edges;
    t_level;
    t_ack;
    wrap_up;
  end

  // The tests need well under a thousand cycles
  initial begin
    cyc(4000);
    err_count++;
    wrap_up;
  end
endmodule
